// file: verilog/imc_consts.svh
// Purpose: shared constants of the imu mode and command control
// Assumes: 200 MHz core clock
// Notes: timing counts derive from the rates below
`ifndef IMC_CONSTS_SVH
`define IMC_CONSTS_SVH

`define IMC_CLK_HZ 200000000
`define IMC_SAMPLE_HZ 2000
`define IMC_SAMPLE_DIV (`IMC_CLK_HZ / `IMC_SAMPLE_HZ)

`define IMC_CHAR_CR 8'h0d
`define IMC_CHAR_N 8'h4e
`define IMC_CHAR_I 8'h49
`define IMC_CHAR_C 8'h43
`define IMC_CHAR_T 8'h54
`define IMC_CHAR_E 8'h45
`define IMC_CHAR_R 8'h52
`define IMC_WORD_MAINT 88'h53455256494345_4d4f4445
`define IMC_WORD_OFFSET 56'h42544f4d4f4445
`define IMC_LEN_MAINT 4'hb
`define IMC_LEN_OFFSET 4'h7
`define IMC_BUF_CHARS 11

`define IMC_AXES 9
`define IMC_AXIS_W 24
`define IMC_STAT_W 8
`define IMC_EXT_W 16
`define IMC_TRIM_RST 24'h000000
`define IMC_RATE_RST 16'h0001

`endif

// file: verilog/imc_pkg.sv
// Purpose: types of the imu mode and command control
// Assumes: nothing
// Notes: binary codes are fixed
`default_nettype none
package imc_pkg;
   typedef enum logic [1:0] {
      IMC_MODE_INIT = 2'b00,
      IMC_MODE_NORMAL = 2'b01,
      IMC_MODE_MAINT = 2'b10,
      IMC_MODE_OFFSET = 2'b11
   } imc_mode_e;
   typedef enum logic [2:0] {
      IMC_DG_MEAS = 3'b000,
      IMC_DG_PART = 3'b001,
      IMC_DG_SERIAL = 3'b010,
      IMC_DG_CONFIG = 3'b011,
      IMC_DG_TRIM = 3'b100,
      IMC_DG_EXTERR = 3'b101,
      IMC_DG_INFO = 3'b110,
      IMC_DG_ACK = 3'b111
   } imc_dg_e;
   typedef enum logic [3:0] {
      IMC_CMD_NONE = 4'h0,
      IMC_CMD_PART = 4'h1,
      IMC_CMD_SERIAL = 4'h2,
      IMC_CMD_CONFIG = 4'h3,
      IMC_CMD_TRIM = 4'h4,
      IMC_CMD_EXTERR = 4'h5,
      IMC_CMD_RESET = 4'h6,
      IMC_CMD_MAINT = 4'h7,
      IMC_CMD_OFFSET = 4'h8
   } imc_cmd_e;
endpackage
`default_nettype wire

// file: verilog/imc_mode_ctrl.sv
// Purpose: mode control, command parsing and datagram scheduling
// Assumes: rx bytes, error flags and tx_busy come from logic on clk
// Notes:
// Notes on behaviour
// (R1) temperature field 16-bit signed, MSB first
// (R2) 8-bit sample counter wraps silently
// (R3) latency field 16-bit microseconds, MSB first
// (R4) add trim offset after compensation
// (R5) offsets kept in rate or g units
// (R6) maintenance entry sends info datagram at once
// (R7) maintenance mode samples but sends nothing
// (R8) external reset forces init, reloads config
// (R9) maintenance exit chooses init or normal
// (R10) offset mode entry stops datagrams, acknowledges
// (R11) offset mode exit resumes normal datagrams
// (R12) status bits OR over subsamples
// (R13) status bits not latched past transmission
// (R14) extended errors cleared on three events
// (R15) host sends upper-case known commands only
// (R16) carriage return ends and executes command
// (R17) no echo, act only on exact command
// (R18) increments during special datagram dropped
// (R19) special datagram replaces next measurement slot
// (R20) external trigger mode: special on trigger
// (R21) self-check results feed the status bits
// (R22) receive buffer cleared on every return
`include "imc_consts.svh"
`default_nettype none
module imc_mode_ctrl
   import imc_pkg::*;
#(
   parameter int SAMPLE_DIV = `IMC_SAMPLE_DIV,
   parameter int AXES = `IMC_AXES,
   parameter int AXIS_W = `IMC_AXIS_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins from outside the clock domain
   input wire logic ext_reset_n,
   input wire logic external_sample_trigger,
   // received command characters
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   // configuration
   input wire logic trig_mode,
   input wire logic [15:0] out_rate_div,
   input wire logic flash_load_done,
   output logic flash_load_req,
   // maintenance and offset mode exits, maintenance error report done
   input wire logic maint_exit_valid,
   input wire logic maint_exit_to_normal,
   input wire logic maint_err_report_done,
   input wire logic offset_exit,
   // bias trim offset writes
   input wire logic trim_wr,
   input wire logic [3:0] trim_axis,
   input wire logic [AXIS_W-1:0] trim_value,
   // measurement inputs
   input wire logic [AXES*AXIS_W-1:0] comp_data,
   input wire logic [15:0] temp_in,
   input wire logic [15:0] latency_in,
   input wire logic [`IMC_STAT_W-1:0] check_flags,
   input wire logic [`IMC_EXT_W-1:0] ext_err_flags,
   // datagram transmitter
   input wire logic tx_busy,
   output logic tx_start,
   output imc_dg_e tx_kind,
   output logic meas_discard,
   // datagram fields
   output logic [AXES*AXIS_W-1:0] adj_data,
   output logic [15:0] temp_field,
   output logic [15:0] latency_field,
   output logic [7:0] sample_count,
   output logic [`IMC_STAT_W-1:0] status_field,
   output logic [`IMC_EXT_W-1:0] ext_err_field,
   output imc_mode_e mode
);

   localparam logic [3:0] BUF_MAX = 4'(`IMC_BUF_CHARS);

   function automatic imc_cmd_e decode(input logic [3:0] len,
                                       input logic [87:0] sr);
      decode = IMC_CMD_NONE;
      if (len == 4'h1) begin
         case (sr[7:0])
            `IMC_CHAR_N: decode = IMC_CMD_PART;
            `IMC_CHAR_I: decode = IMC_CMD_SERIAL;
            `IMC_CHAR_C: decode = IMC_CMD_CONFIG;
            `IMC_CHAR_T: decode = IMC_CMD_TRIM;
            `IMC_CHAR_E: decode = IMC_CMD_EXTERR;
            `IMC_CHAR_R: decode = IMC_CMD_RESET;
            default: decode = IMC_CMD_NONE;
         endcase
      end else if (len == `IMC_LEN_MAINT && sr == `IMC_WORD_MAINT) begin
         decode = IMC_CMD_MAINT;
      end else if (len == `IMC_LEN_OFFSET &&
                   sr[55:0] == `IMC_WORD_OFFSET) begin
         decode = IMC_CMD_OFFSET;
      end
   endfunction

   // pin synchronisers
   logic [1:0] xrst_sync_q;
   logic [1:0] trig_sync_q;
   logic trig_prev_q;
   logic xrst_hit;
   logic trig_edge;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xrst_sync_q <= 2'h3;
         trig_sync_q <= 2'h0;
         trig_prev_q <= 1'b0;
      end else begin
         xrst_sync_q <= {xrst_sync_q[0], ext_reset_n};
         trig_sync_q <= {trig_sync_q[0], external_sample_trigger};
         trig_prev_q <= trig_sync_q[1];
      end
   end

   assign xrst_hit = !xrst_sync_q[1];
   assign trig_edge = trig_sync_q[1] && !trig_prev_q;

   // internal sample tick
   logic [31:0] div_q;
   logic tick;

   assign tick = (div_q == 32'(SAMPLE_DIV - 1));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_q <= 32'h0;
      end else if (tick) begin
         div_q <= 32'h0;
      end else begin
         div_q <= div_q + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sample_count <= 8'h00;
      end else if (tick) begin
         sample_count <= sample_count + 8'h01; // see (R2)
      end
   end

   // command receive buffer
   logic [87:0] sr_q;
   logic [3:0] len_q;
   logic ovf_q;
   logic cr_seen;
   imc_cmd_e cmd;

   assign cr_seen = rx_valid && rx_data == `IMC_CHAR_CR; // see (R16)
   // only an exact, complete command decodes; lower case never matches
   assign cmd = (cr_seen && !ovf_q && mode == IMC_MODE_NORMAL) ?
                decode(len_q, sr_q) : IMC_CMD_NONE; // see (R17) (R15)

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sr_q <= 88'h0;
         len_q <= 4'h0;
         ovf_q <= 1'b0;
      end else if (cr_seen) begin
         sr_q <= 88'h0; // see (R22)
         len_q <= 4'h0;
         ovf_q <= 1'b0;
      end else if (rx_valid) begin
         sr_q <= {sr_q[79:0], rx_data};
         if (len_q == BUF_MAX) begin
            ovf_q <= 1'b1;
         end else begin
            len_q <= len_q + 4'h1;
         end
      end
   end

   // mode machine
   always_ff @(posedge clk) begin
      if (!rst_n || xrst_hit) begin
         mode <= IMC_MODE_INIT; // see (R8)
      end else begin
         case (mode)
            IMC_MODE_INIT: begin
               if (flash_load_done) begin
                  mode <= IMC_MODE_NORMAL;
               end
            end
            IMC_MODE_NORMAL: begin
               if (cmd == IMC_CMD_RESET) begin
                  mode <= IMC_MODE_INIT;
               end else if (cmd == IMC_CMD_MAINT) begin
                  mode <= IMC_MODE_MAINT;
               end else if (cmd == IMC_CMD_OFFSET) begin
                  mode <= IMC_MODE_OFFSET; // see (R10)
               end
            end
            IMC_MODE_MAINT: begin
               if (maint_exit_valid) begin
                  // normal keeps unsaved settings; init reloads them
                  mode <= maint_exit_to_normal ? IMC_MODE_NORMAL :
                          IMC_MODE_INIT; // see (R9)
               end
            end
            IMC_MODE_OFFSET: begin
               if (offset_exit) begin
                  mode <= IMC_MODE_NORMAL; // see (R11)
               end
            end
            default: mode <= IMC_MODE_INIT;
         endcase
      end
   end

   // flash reload is requested for the whole of init
   assign flash_load_req = (mode == IMC_MODE_INIT); // see (R8)

   // pending special datagram request
   logic pend_q;
   imc_dg_e pend_kind_q;
   logic slot;
   logic [15:0] rate_cnt_q;
   logic rate_hit;

   assign rate_hit = tick && (rate_cnt_q + 16'h1 >= out_rate_div);
   // a trigger replaces the rate divider in trigger mode
   assign slot = (mode == IMC_MODE_NORMAL) &&
                 (trig_mode ? trig_edge : rate_hit); // see (R20)

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rate_cnt_q <= 16'h0;
      end else if (rate_hit) begin
         rate_cnt_q <= 16'h0;
      end else if (tick) begin
         rate_cnt_q <= rate_cnt_q + 16'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || mode != IMC_MODE_NORMAL) begin
         pend_q <= 1'b0;
         pend_kind_q <= IMC_DG_MEAS;
      end else begin
         if (slot && !tx_busy) begin
            pend_q <= 1'b0;
         end
         // a new request arriving in the taking slot is kept
         case (cmd)
            IMC_CMD_PART: begin
               pend_q <= 1'b1;
               pend_kind_q <= IMC_DG_PART;
            end
            IMC_CMD_SERIAL: begin
               pend_q <= 1'b1;
               pend_kind_q <= IMC_DG_SERIAL;
            end
            IMC_CMD_CONFIG: begin
               pend_q <= 1'b1;
               pend_kind_q <= IMC_DG_CONFIG;
            end
            IMC_CMD_TRIM: begin
               pend_q <= 1'b1;
               pend_kind_q <= IMC_DG_TRIM;
            end
            IMC_CMD_EXTERR: begin
               pend_q <= 1'b1;
               pend_kind_q <= IMC_DG_EXTERR;
            end
            default: begin
            end
         endcase
      end
   end

   // datagram start and discard
   logic send_special;
   logic send_meas;

   // a busy transmitter swallows the slot: longer datagrams displace
   assign send_special = slot && !tx_busy && pend_q; // see (R19)
   assign send_meas = slot && !tx_busy && !pend_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_start <= 1'b0;
         tx_kind <= IMC_DG_MEAS;
      end else begin
         tx_start <= 1'b0;
         if (cmd == IMC_CMD_MAINT) begin
            tx_start <= 1'b1;
            tx_kind <= IMC_DG_INFO; // see (R6)
         end else if (cmd == IMC_CMD_OFFSET) begin
            tx_start <= 1'b1;
            tx_kind <= IMC_DG_ACK; // see (R10)
         end else if (send_special) begin
            tx_start <= 1'b1;
            tx_kind <= pend_kind_q; // see (R19) (R20)
         end else if (send_meas) begin
            tx_start <= 1'b1; // see (R7) only normal mode slots
            tx_kind <= IMC_DG_MEAS;
         end
      end
   end

   // increments gathered over a special datagram or a silent mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meas_discard <= 1'b0;
      end else begin
         meas_discard <= send_special ||
                         (tick && mode != IMC_MODE_NORMAL); // see (R18) (R7)
      end
   end

   // bias trim offsets and adjusted data
   logic [AXIS_W-1:0] trim_q [AXES];

   // offsets stay in rate or g units whatever the output unit
   always_ff @(posedge clk) begin
      if (!rst_n || mode == IMC_MODE_INIT) begin
         for (int i = 0; i < AXES; i++) begin
            trim_q[i] <= `IMC_TRIM_RST;
         end
      end else if (trim_wr && 32'(trim_axis) < AXES) begin
         trim_q[trim_axis] <= trim_value; // see (R5)
      end
   end

   // sampling continues in every mode so filters stay settled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         adj_data <= '0;
      end else if (tick) begin
         for (int i = 0; i < AXES; i++) begin
            adj_data[i*AXIS_W +: AXIS_W] <=
               comp_data[i*AXIS_W +: AXIS_W] + trim_q[i]; // see (R4) (R7)
         end
      end
   end

   // temperature and latency fields, bits 15:8 go out first
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         temp_field <= 16'h0000;
         latency_field <= 16'h0000;
      end else if (send_meas) begin
         temp_field <= temp_in; // see (R1)
         latency_field <= latency_in; // see (R3)
      end
   end

   // status accumulation over subsamples
   logic [`IMC_STAT_W-1:0] stat_acc_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stat_acc_q <= '0;
         status_field <= '0;
      end else if (send_meas) begin
         // snapshot then restart; this cycle's flags belong to it
         status_field <= stat_acc_q | check_flags; // see (R12) (R21)
         stat_acc_q <= '0; // see (R13)
      end else begin
         stat_acc_q <= stat_acc_q | check_flags; // see (R12) (R21)
      end
   end

   // extended error accumulation
   logic ext_clr;

   assign ext_clr = (mode == IMC_MODE_INIT && flash_load_done) ||
                    (send_special && pend_kind_q == IMC_DG_EXTERR) ||
                    maint_err_report_done; // see (R14)

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext_err_field <= '0;
      end else if (ext_clr) begin
         // new errors in the clearing cycle are kept
         ext_err_field <= ext_err_flags; // see (R14)
      end else begin
         ext_err_field <= ext_err_field | ext_err_flags;
      end
   end

endmodule
`default_nettype wire

// file: verif/imc_host_model.sv
// Purpose: host that types commands into the receive port
// Assumes: one byte per clock, driven after the rising edge
// Notes: the idle data line shows the inverse of the last byte
`include "imc_consts.svh"
`default_nettype none
module imc_host_model (
   // clock
   input wire logic clk,
   // command bytes
   output logic rx_valid,
   output logic [7:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
   end
   // text, then the execution character
   task automatic send(input string s);
      @(posedge clk);
      for (int i = 0; i <= s.len(); i++) begin
         rx_valid <= 1'b1;
         rx_data <= (i == s.len()) ? `IMC_CHAR_CR : s[i];
         @(posedge clk);
      end
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
   endtask
endmodule
`default_nettype wire

// file: verif/imc_mode_ctrl_asserts.sv
// Purpose: port checker of the mode and command control
// Assumes: one clock, synchronous reset
// Notes: attached by bind below
`include "imc_consts.svh"
`default_nettype none
module imc_mode_ctrl_asserts
   import imc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // inputs watched
   input wire logic ext_reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic maint_exit_valid,
   input wire logic maint_exit_to_normal,
   input wire logic offset_exit,
   // outputs watched
   input wire logic flash_load_req,
   input wire logic tx_start,
   input var imc_dg_e tx_kind,
   input wire logic meas_discard,
   input wire logic [7:0] sample_count,
   input var imc_mode_e mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_pin_low;
      !ext_reset_n [*4];
   endsequence
   sequence s_char;
      rx_valid && rx_data != `IMC_CHAR_CR && mode == IMC_MODE_NORMAL;
   endsequence
   property p_pin; s_pin_low |-> mode == IMC_MODE_INIT; endproperty
   a_pin: assert property (p_pin)
      else $error("pin reset did not reach init");
   property p_req; flash_load_req == (mode == IMC_MODE_INIT); endproperty
   a_req: assert property (p_req)
      else $error("reload request not tied to init");
   property p_cnt;
      $changed(sample_count) |-> sample_count == $past(sample_count) + 8'h01;
   endproperty
   a_cnt: assert property (p_cnt)
      else $error("sample counter skipped");
   property p_mi;
      $rose(mode == IMC_MODE_MAINT) |-> tx_start && tx_kind == IMC_DG_INFO;
   endproperty
   a_mi: assert property (p_mi)
      else $error("no info datagram on maintenance entry");
   property p_mq; mode == IMC_MODE_MAINT && $stable(mode) |-> !tx_start;
   endproperty
   a_mq: assert property (p_mq)
      else $error("datagram sent in maintenance");
   property p_oi;
      $rose(mode == IMC_MODE_OFFSET) |-> tx_start && tx_kind == IMC_DG_ACK;
   endproperty
   a_oi: assert property (p_oi)
      else $error("no acknowledge on offset entry");
   property p_oq; mode == IMC_MODE_OFFSET && $stable(mode) |-> !tx_start;
   endproperty
   a_oq: assert property (p_oq)
      else $error("datagram sent in offset mode");
   property p_mx;
      mode == IMC_MODE_MAINT && maint_exit_valid |=> mode ==
         (maint_exit_to_normal ? IMC_MODE_NORMAL : IMC_MODE_INIT);
   endproperty
   a_mx: assert property (p_mx)
      else $error("maintenance exit went wrong way");
   property p_ox; mode == IMC_MODE_OFFSET && offset_exit |=>
      mode == IMC_MODE_NORMAL; endproperty
   a_ox: assert property (p_ox)
      else $error("offset exit did not reach normal");
   property p_disc; tx_start && tx_kind != IMC_DG_MEAS &&
      mode == IMC_MODE_NORMAL |-> meas_discard; endproperty
   a_disc: assert property (p_disc)
      else $error("increments kept across special datagram");
   property p_echo; s_char |=> mode == IMC_MODE_NORMAL &&
      !(tx_start && tx_kind == IMC_DG_INFO); endproperty
   a_echo: assert property (p_echo)
      else $error("plain character caused an action");
endmodule
bind imc_mode_ctrl imc_mode_ctrl_asserts u_imc_mode_ctrl_asserts (
   .clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
   .rx_valid(rx_valid), .rx_data(rx_data),
   .maint_exit_valid(maint_exit_valid),
   .maint_exit_to_normal(maint_exit_to_normal),
   .offset_exit(offset_exit), .flash_load_req(flash_load_req),
   .tx_start(tx_start), .tx_kind(tx_kind), .meas_discard(meas_discard),
   .sample_count(sample_count), .mode(mode)
);
`default_nettype wire

// file: verif/imc_mode_ctrl_bench.sv
// Purpose: self-checking bench of the mode and command control
// Assumes: short sample divider of 10 clocks
// Notes: waits for starts under a bounded count
`default_nettype none
module imc_mode_ctrl_bench
   import imc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 10;
   logic clk = 1'b0, rst_n = 1'b0, ext_reset_n = 1'b1;
   logic external_sample_trigger = 1'b0, trig_mode = 1'b0;
   logic rx_valid, flash_load_req, tx_start, meas_discard;
   logic [7:0] rx_data, sample_count, status_field;
   logic [7:0] check_flags = 8'h00;
   logic [15:0] out_rate_div = 16'h0002;
   logic flash_load_done = 1'b0, maint_exit_valid = 1'b0;
   logic maint_exit_to_normal = 1'b1, maint_err_report_done = 1'b0;
   logic offset_exit = 1'b0, trim_wr = 1'b0, tx_busy = 1'b0;
   logic [3:0] trim_axis = 4'h2;
   logic [23:0] trim_value = 24'h000005;
   logic [215:0] comp_data = '0, adj_data;
   logic [15:0] temp_in = 16'hfe80, latency_in = 16'h1234;
   logic [15:0] ext_err_flags = 16'h0000;
   logic [15:0] temp_field, latency_field, ext_err_field;
   imc_dg_e tx_kind;
   imc_mode_e mode;
   int num_errors = 0;
   int compares = 0;
   string cmds[5] = '{"N", "I", "C", "T", "E"};
   imc_dg_e kinds[5] = '{IMC_DG_PART, IMC_DG_SERIAL, IMC_DG_CONFIG,
                         IMC_DG_TRIM, IMC_DG_EXTERR};

   imc_mode_ctrl #(.SAMPLE_DIV(DIV)) u_imc_mode_ctrl (
      .clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
      .external_sample_trigger(external_sample_trigger),
      .rx_valid(rx_valid), .rx_data(rx_data), .trig_mode(trig_mode),
      .out_rate_div(out_rate_div), .flash_load_done(flash_load_done),
      .flash_load_req(flash_load_req),
      .maint_exit_valid(maint_exit_valid),
      .maint_exit_to_normal(maint_exit_to_normal),
      .maint_err_report_done(maint_err_report_done),
      .offset_exit(offset_exit), .trim_wr(trim_wr),
      .trim_axis(trim_axis), .trim_value(trim_value),
      .comp_data(comp_data), .temp_in(temp_in), .latency_in(latency_in),
      .check_flags(check_flags), .ext_err_flags(ext_err_flags),
      .tx_busy(tx_busy), .tx_start(tx_start), .tx_kind(tx_kind),
      .meas_discard(meas_discard), .adj_data(adj_data),
      .temp_field(temp_field), .latency_field(latency_field),
      .sample_count(sample_count), .status_field(status_field),
      .ext_err_field(ext_err_field), .mode(mode)
   );
   imc_host_model u_imc_host_model (.clk(clk), .rx_valid(rx_valid),
                                    .rx_data(rx_data));

   always #2.5 clk = ~clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   // first start, checked against kind k; measurement starts are passed over unless k is the measurement kind
   task automatic ws(input imc_dg_e k);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!(tx_start && (tx_kind != IMC_DG_MEAS ||
                 k == IMC_DG_MEAS)) && n < 100);
      chk({tx_start, tx_kind}, {1'b1, k});
   endtask

   // starts seen over a span of cycles
   task automatic quiet(input int cyc, output int n);
      n = 0;
      repeat (cyc) begin
         @(negedge clk);
         n += int'(tx_start);
      end
   endtask

   task automatic wrap_up();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (8000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   initial begin
      logic [7:0] c1;
      int n;
      string w_maint;
      string w_offset;
      // mode entry words are assembled from halves
      w_maint = "SERVICE";
      w_maint = {w_maint, "MODE"};
      w_offset = "BTO";
      w_offset = {w_offset, "MODE"};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(mode, IMC_MODE_INIT);
      chk(flash_load_req, 1'b1);
      @(posedge clk) flash_load_done <= 1'b1;
      @(posedge clk) flash_load_done <= 1'b0;
      comp_data[71:48] <= 24'h000064;
      trim_wr <= 1'b1;
      @(posedge clk) trim_wr <= 1'b0;
      repeat (DIV + 2) @(negedge clk);
      chk(mode, IMC_MODE_NORMAL);
      chk(adj_data[71:48], 24'h000069);
      ws(IMC_DG_MEAS);
      c1 = sample_count;
      chk(temp_field, 16'hfe80);
      chk(latency_field, 16'h1234);
      @(posedge clk) check_flags <= 8'h04;
      repeat (DIV) @(posedge clk);
      check_flags <= 8'h00;
      ws(IMC_DG_MEAS);
      chk(8'(sample_count - c1), 8'h02);
      chk(status_field, 8'h04);
      ws(IMC_DG_MEAS);
      chk(status_field, 8'h00);
      @(posedge clk) tx_busy <= 1'b1;
      quiet(2600, n);
      chk(n, 0);
      @(posedge clk) tx_busy <= 1'b0;
      ws(IMC_DG_MEAS);
      chk(status_field, 8'h00);
      foreach (cmds[i]) begin
         u_imc_host_model.send(cmds[i]);
         ws(kinds[i]);
         chk(meas_discard, 1'b1);
      end
      u_imc_host_model.send("n");
      ws(IMC_DG_MEAS);
      u_imc_host_model.send("I");
      ws(IMC_DG_SERIAL);
      @(posedge clk) ext_err_flags <= 16'h0010;
      @(posedge clk) ext_err_flags <= 16'h0000;
      repeat (2) @(negedge clk);
      chk(ext_err_field, 16'h0010);
      @(posedge clk) maint_err_report_done <= 1'b1;
      @(posedge clk) maint_err_report_done <= 1'b0;
      @(negedge clk);
      chk(ext_err_field, 16'h0000);
      u_imc_host_model.send(w_maint);
      ws(IMC_DG_INFO);
      chk(mode, IMC_MODE_MAINT);
      u_imc_host_model.send("N");
      quiet(30, n);
      chk(n, 0);
      @(posedge clk) maint_exit_valid <= 1'b1;
      @(posedge clk) maint_exit_valid <= 1'b0;
      ws(IMC_DG_MEAS);
      u_imc_host_model.send(w_offset);
      ws(IMC_DG_ACK);
      chk(mode, IMC_MODE_OFFSET);
      quiet(30, n);
      chk(n, 0);
      @(posedge clk) offset_exit <= 1'b1;
      @(posedge clk) offset_exit <= 1'b0;
      ws(IMC_DG_MEAS);
      @(posedge clk) trig_mode <= 1'b1;
      u_imc_host_model.send("C");
      quiet(40, n);
      chk(n, 0);
      @(posedge clk) external_sample_trigger <= 1'b1;
      ws(IMC_DG_CONFIG);
      @(posedge clk) external_sample_trigger <= 1'b0;
      trig_mode <= 1'b0;
      ext_reset_n <= 1'b0;
      ext_err_flags <= 16'h0020;
      @(posedge clk) ext_err_flags <= 16'h0000;
      repeat (4) @(negedge clk);
      chk(mode, IMC_MODE_INIT);
      chk(ext_err_field, 16'h0020);
      @(posedge clk) ext_reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      flash_load_done <= 1'b1;
      @(posedge clk) flash_load_done <= 1'b0;
      u_imc_host_model.send("R");
      repeat (3) @(negedge clk);
      chk(mode, IMC_MODE_INIT);
      chk(ext_err_field, 16'h0000);
      // second maintenance visit leaves through init
      @(posedge clk) flash_load_done <= 1'b1;
      @(posedge clk) flash_load_done <= 1'b0;
      maint_exit_to_normal <= 1'b0;
      u_imc_host_model.send(w_maint);
      ws(IMC_DG_INFO);
      @(posedge clk) maint_exit_valid <= 1'b1;
      @(posedge clk) maint_exit_valid <= 1'b0;
      @(negedge clk);
      chk(mode, IMC_MODE_INIT);
      chk(flash_load_req, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
